// ===== rtl/cab_pkg.sv
// Purpose: constants and types for the execution core
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: opcodes are a compact internal encoding of the decoded instruction
// How it works
// - Add with carry: d plus s plus C, flags Z C N V H, one cycle.
// - Subtract with carry: d minus s minus C, flags Z C N V H, one cycle.
// - Subtract constant from register in one cycle with Z C N V H.
// - Word plus immediate on a pair takes two cycles, flags Z C N V S.
// - Word minus immediate on a pair takes two cycles, flags Z C N V S.
// - And, or, exclusive or take one cycle, change only Z N V.
// - Mask clear is and with 0xff minus mask, flags Z N V.
// - Zero-minus check ands register with itself, Z N V, one cycle.
// - Multiplies write 16-bit product to R1:R0 in two cycles, Z and C.
// - Fractional multiplies shift product left one, two cycles, Z and C.
// - Relative call sets pc to pc plus offset plus one, three cycles.
// - Direct call loads absolute target, four cycles.
// - Pointer jump loads pc from Z in two cycles, flags unchanged.
// - Pointer call loads pc from Z in three cycles, flags unchanged.
// - Compare-skip-equal advances pc by 2 or 3 on match, 1/2/3 cycles.
// - Compare immediate sets Z N V C H only, register not written.
// - Register bit skip tests one bit, skips next on match, 1 to 3 cycles.
// - I/O bit skip tests one I/O bit, skips next on match.
// - Flag branch: pc plus offset plus one when flag matches; 1 or 2 cycles.
// - Carry-clear and same-or-higher branches taken when carry is zero.
// - Single-bit I/O set and clear reach addresses 0x00 to 0x1f only.
// - Bit set/clear rewrite the whole I/O register read-modify-write.
package cab_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	// Register offsets
	localparam logic [5:0] OFS_STATUS = 6'h3f;
	localparam logic [5:0] OFS_SP_HIGH = 6'h3e;
	localparam logic [5:0] OFS_SP_LOW = 6'h3d;
	localparam logic [5:0] IO_BIT_MAX = 6'h1f;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [15:0] SP_RST = 16'h0000;
	localparam logic [7:0] ALL_ONES = 8'hff;
	// Status bit positions
	localparam int unsigned FL_C = 0;
	localparam int unsigned FL_Z = 1;
	localparam int unsigned FL_N = 2;
	localparam int unsigned FL_V = 3;
	localparam int unsigned FL_S = 4;
	localparam int unsigned FL_H = 5;
	localparam int unsigned FL_T = 6;
	localparam int unsigned FL_I = 7;
	// Cycle counts
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;
	localparam logic [15:0] PC_RST = 16'h0000;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
		OP_SBC = 5'h04, OP_MINUS_CONSTANT = 5'h05, OP_WORD_PLUS_IMMEDIATE = 5'h06, OP_WORD_MINUS_IMMEDIATE = 5'h07,
		OP_AND = 5'h08, OP_OR = 5'h09, OP_EOR = 5'h0a, OP_CBR = 5'h0b,
		OP_TST = 5'h0c, OP_MUL = 5'h0d, OP_MULS = 5'h0e, OP_MIXED_SIGN_PRODUCT = 5'h0f,
		OP_FRACTIONAL_PRODUCT = 5'h10, OP_FMULS = 5'h11, OP_FMULSU = 5'h12, OP_RELATIVE_SUBROUTINE_JUMP = 5'h13,
		OP_CALL = 5'h14, OP_POINTER_JUMP = 5'h15, OP_POINTER_SUBROUTINE_JUMP = 5'h16, OP_COMPARE_SKIP_EQUAL = 5'h17,
		OP_CPI = 5'h18, OP_SKRB = 5'h19, OP_SKIO = 5'h1a, OP_BRFLAG = 5'h1b,
		OP_BRANCH_SAME_HIGHER = 5'h1c, OP_IOSET = 5'h1d, OP_IOCLR = 5'h1e, OP_INTERRUPT_RETURN = 5'h1f
	} cab_op_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} cab_state_type;

	// One decoded instruction
	typedef struct packed {
		cab_op_type op;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] dst_hi;
		logic [2:0] bsel;
		logic pol;
		logic [15:0] target;
		logic next_two_word;
		logic [5:0] io_addr;
	} cab_instr_type;

	// Result of one instruction
	typedef struct packed {
		logic [7:0] res_lo;
		logic [7:0] res_hi;
		logic wr_lo;
		logic wr_hi;
		logic wr_pair;
		logic [5:0] io_addr;
		logic [7:0] io_wdata;
		logic io_wr;
	} cab_result_type;
endpackage

// ===== rtl/cab_core.sv
// Purpose: arithmetic, logic, multiply, jump, call, skip and branch execution
// Assumes: caller presents decoded operands; one instruction per issue
// Notes: busy holds until the documented cycle count has elapsed
//
// Added by the designer: the plain strobed port.
module cab_core
	import cab_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic issue,
	input wire cab_pkg::cab_instr_type instr,
	input wire logic [15:0] z_ptr,
	input wire logic [15:0] stack_pc,
	input wire logic [7:0] io_rdata,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output cab_pkg::cab_result_type result,
	output logic result_valid,
	output logic busy,
	output logic [15:0] pc,
	output logic [7:0] status,
	output logic [15:0] stack_ptr
);
	import cab_pkg::*;

	cab_state_type state_q;
	logic [2:0] cnt_q;
	logic [7:0] status_q, status_d;
	logic [15:0] sp_q;
	logic [15:0] pc_q, pc_d;
	logic [2:0] cyc_d;
	logic [7:0] rdata_q;
	cab_result_type res_q, res_d;
	logic valid_q;
	logic busy_q;

	// =========================================================
	// Execute
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [16:0] w17;
	logic [15:0] prod;
	logic [7:0] lg;
	logic cin, test_bit, skip;
	always_comb begin
		status_d = status_q;
		res_d = '0;
		pc_d = pc_q + 16'h0001;
		cyc_d = CYC_ONE;
		sum9 = '0;
		sum5 = '0;
		w17 = '0;
		prod = '0;
		lg = '0;
		cin = 1'b0;
		test_bit = 1'b0;
		skip = 1'b0;
		case (instr.op)
			OP_ADD, OP_ADC: begin
				cin = (instr.op == OP_ADC) ? status_q[FL_C] : 1'b0;
				sum9 = {1'b0, instr.dst} + {1'b0, instr.src} + {8'h00, cin};
				sum5 = {1'b0, instr.dst[3:0]} + {1'b0, instr.src[3:0]} + {4'h0, cin};
				res_d.res_lo = sum9[7:0];
				res_d.wr_lo = 1'b1;
				status_d[FL_C] = sum9[8];
				status_d[FL_H] = sum5[4];
				status_d[FL_V] = (instr.dst[7] == instr.src[7]) && (sum9[7] != instr.dst[7]);
			end
			OP_SUB, OP_SBC, OP_MINUS_CONSTANT, OP_CPI: begin
				cin = (instr.op == OP_SBC) ? status_q[FL_C] : 1'b0;
				sum9 = {1'b0, instr.dst} - {1'b0, instr.src} - {8'h00, cin};
				sum5 = {1'b0, instr.dst[3:0]} - {1'b0, instr.src[3:0]} - {4'h0, cin};
				res_d.res_lo = sum9[7:0];
				res_d.wr_lo = (instr.op != OP_CPI);
				status_d[FL_C] = sum9[8];
				status_d[FL_H] = sum5[4];
				status_d[FL_V] = (instr.dst[7] != instr.src[7]) && (sum9[7] != instr.dst[7]);
			end
			OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
				if (instr.op == OP_WORD_PLUS_IMMEDIATE) begin
					w17 = {1'b0, instr.dst_hi, instr.dst} + {9'h000, instr.src};
					status_d[FL_V] = !instr.dst_hi[7] && w17[15];
					status_d[FL_C] = !w17[15] && instr.dst_hi[7];
				end else begin
					w17 = {1'b0, instr.dst_hi, instr.dst} - {9'h000, instr.src};
					status_d[FL_V] = instr.dst_hi[7] && !w17[15];
					status_d[FL_C] = w17[15] && !instr.dst_hi[7];
				end
				res_d.res_lo = w17[7:0];
				res_d.res_hi = w17[15:8];
				res_d.wr_pair = 1'b1;
				cyc_d = CYC_TWO;
			end
			OP_AND, OP_OR, OP_EOR, OP_CBR, OP_TST: begin
				case (instr.op)
					OP_OR: lg = instr.dst | instr.src;
					OP_EOR: lg = instr.dst ^ instr.src;
					OP_CBR: lg = instr.dst & (ALL_ONES - instr.src);
					OP_TST: lg = instr.dst & instr.dst;
					default: lg = instr.dst & instr.src;
				endcase
				res_d.res_lo = lg;
				res_d.wr_lo = 1'b1;
				status_d[FL_V] = 1'b0;
			end
			OP_MUL, OP_MULS, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_PRODUCT, OP_FMULS, OP_FMULSU: begin
				case (instr.op)
					OP_MULS, OP_FMULS:
						prod = 16'($signed({{8{instr.dst[7]}}, instr.dst}) *
							$signed({{8{instr.src[7]}}, instr.src}));
					OP_MIXED_SIGN_PRODUCT, OP_FMULSU:
						prod = 16'($signed({{8{instr.dst[7]}}, instr.dst}) *
							$signed({8'h00, instr.src}));
					default: prod = {8'h00, instr.dst} * {8'h00, instr.src};
				endcase
				status_d[FL_C] = prod[15];
				if (instr.op == OP_FRACTIONAL_PRODUCT || instr.op == OP_FMULS || instr.op == OP_FMULSU)
					prod = {prod[14:0], 1'b0};
				res_d.res_lo = prod[7:0];
				res_d.res_hi = prod[15:8];
				res_d.wr_pair = 1'b1;
				status_d[FL_Z] = (prod == 16'h0000);
				cyc_d = CYC_TWO;
			end
			OP_RELATIVE_SUBROUTINE_JUMP: begin
				pc_d = pc_q + instr.target + 16'h0001;
				cyc_d = CYC_THREE;
			end
			OP_CALL: begin
				pc_d = instr.target;
				cyc_d = CYC_FOUR;
			end
			OP_POINTER_JUMP: begin
				pc_d = z_ptr;
				cyc_d = CYC_TWO;
			end
			OP_POINTER_SUBROUTINE_JUMP: begin
				pc_d = z_ptr;
				cyc_d = CYC_THREE;
			end
			OP_INTERRUPT_RETURN: begin
				pc_d = stack_pc;
				status_d[FL_I] = 1'b1;
				cyc_d = CYC_FOUR;
			end
			OP_COMPARE_SKIP_EQUAL, OP_SKRB, OP_SKIO: begin
				if (instr.op == OP_COMPARE_SKIP_EQUAL)
					skip = (instr.dst == instr.src);
				else if (instr.op == OP_SKRB)
					skip = (instr.dst[instr.bsel] == instr.pol);
				else
					skip = (io_rdata[instr.bsel] == instr.pol);
				if (skip) begin
					pc_d = pc_q + (instr.next_two_word ? 16'h0003 : 16'h0002);
					cyc_d = instr.next_two_word ? CYC_THREE : CYC_TWO;
				end
			end
			OP_BRFLAG, OP_BRANCH_SAME_HIGHER: begin
				test_bit = (instr.op == OP_BRANCH_SAME_HIGHER) ? status_q[FL_C] : status_q[instr.bsel];
				// Same-or-higher is carry-clear
				if (test_bit == ((instr.op == OP_BRANCH_SAME_HIGHER) ? 1'b0 : instr.pol)) begin
					pc_d = pc_q + instr.target + 16'h0001;
					cyc_d = CYC_TWO;
				end
			end
			OP_IOSET, OP_IOCLR: begin
				if (instr.io_addr <= IO_BIT_MAX) begin
					res_d.io_addr = instr.io_addr;
					res_d.io_wdata = io_rdata;
					res_d.io_wdata[instr.bsel] = (instr.op == OP_IOSET);
					res_d.io_wr = 1'b1;
				end
			end
			default: begin
			end
		endcase
		// Common zero, negative and sign updates
		case (instr.op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_MINUS_CONSTANT, OP_CPI,
			OP_AND, OP_OR, OP_EOR, OP_CBR, OP_TST: begin
				// Byte ops leave the sign flag alone
				status_d[FL_N] = res_d.res_lo[7];
				if (instr.op == OP_SBC)
					status_d[FL_Z] = (res_d.res_lo == 8'h00) && status_q[FL_Z];
				else
					status_d[FL_Z] = (res_d.res_lo == 8'h00);
			end
			OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
				status_d[FL_N] = w17[15];
				status_d[FL_S] = w17[15] ^ status_d[FL_V];
				status_d[FL_Z] = (w17[15:0] == 16'h0000);
			end
			default: begin
			end
		endcase
	end

	// =========================================================
	// Sequencer
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			cnt_q <= 3'h0;
			pc_q <= PC_RST;
			res_q <= '0;
			valid_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (clk_en) begin
			valid_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (issue) begin
						busy_q <= 1'b1;
						pc_q <= pc_d;
						res_q <= res_d;
						cnt_q <= cyc_d;
						state_q <= (cyc_d == CYC_ONE) ? ST_DONE : ST_BUSY;
					end
				end
				ST_BUSY: begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == CYC_TWO)
						state_q <= ST_DONE;
				end
				ST_DONE: begin
					valid_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				default: begin
					busy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// =========================================================
	// Status register from software or execution, stack pointer from software only
	always_ff @(posedge core_clk) begin
		if (srst) begin
			status_q <= STATUS_RST;
		end else if (clk_en) begin
			if (state_q == ST_IDLE && issue)
				status_q <= status_d;
			else if (reg_wr && reg_addr == OFS_STATUS)
				status_q <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sp_q <= SP_RST;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == OFS_SP_HIGH)
				sp_q[15:8] <= reg_wdata;
			else if (reg_addr == OFS_SP_LOW)
				sp_q[7:0] <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					OFS_STATUS: rdata_q <= status_q;
					OFS_SP_HIGH: rdata_q <= sp_q[15:8];
					OFS_SP_LOW: rdata_q <= sp_q[7:0];
					default: rdata_q <= 8'h00;
				endcase
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign result = res_q;
	assign result_valid = valid_q;
	assign busy = busy_q;
	assign pc = pc_q;
	assign status = status_q;
	assign stack_ptr = sp_q;
endmodule

// ===== bench/cab_core_properties.sv
// Purpose: port-level timing and result checks for the execution core
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every cab_core instance
module cab_core_properties
	import cab_pkg::*;
(
	input logic core_clk,
	input logic srst,
	input logic clk_en,
	input logic issue,
	input cab_pkg::cab_instr_type instr,
	input logic [15:0] z_ptr,
	input logic [15:0] stack_pc,
	input logic [5:0] reg_addr,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	input cab_pkg::cab_result_type result,
	input logic result_valid,
	input logic busy,
	input logic [15:0] pc,
	input logic [7:0] status,
	input logic [15:0] stack_ptr
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Checks
	logic take;
	assign take = issue && !busy && clk_en;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_one_cycle_ops: assert property (
		take && instr.op inside {OP_ADC, OP_SBC, OP_MINUS_CONSTANT, OP_AND, OP_OR, OP_EOR, OP_CBR, OP_TST,
		OP_CPI} |=> busy ##1 (result_valid && !busy)) else $error("one cycle op timing");
	a_two_cycle_ops: assert property (
		take && instr.op inside {OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE, OP_MUL, OP_MULS, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_PRODUCT, OP_FMULS,
		OP_FMULSU, OP_POINTER_JUMP} |=> busy [*2] ##1 result_valid) else $error("two cycle op timing");
	a_call_timing: assert property (
		take && instr.op inside {OP_RELATIVE_SUBROUTINE_JUMP, OP_POINTER_SUBROUTINE_JUMP} |=> busy [*3] ##1 result_valid)
		else $error("three cycle call timing");
	a_rel_call: assert property (
		take && instr.op == OP_RELATIVE_SUBROUTINE_JUMP |=> pc == $past(pc) + $past(instr.target) + 16'h1)
		else $error("relative call target");
	a_ptr_jump: assert property (
		take && instr.op inside {OP_POINTER_JUMP, OP_POINTER_SUBROUTINE_JUMP} |=> pc == $past(z_ptr) && $stable(status))
		else $error("pointer jump target");
	a_direct_call: assert property (
		take && instr.op == OP_CALL |=> pc == $past(instr.target) ##1 busy [*3] ##1 result_valid)
		else $error("direct call");
	a_int_return: assert property (
		take && instr.op == OP_INTERRUPT_RETURN |=> pc == $past(stack_pc) && status[FL_I])
		else $error("interrupt return");
	a_carry_branch: assert property (
		take && instr.op == OP_BRANCH_SAME_HIGHER |=> pc == $past(pc) +
		($past(status[FL_C]) ? 16'h1 : $past(instr.target) + 16'h1)) else $error("carry branch");
	a_compare_keep: assert property (
		take && instr.op == OP_CPI |=> !result.wr_lo) else $error("compare wrote register");
	a_io_range: assert property (
		result.io_wr |-> result.io_addr <= IO_BIT_MAX) else $error("bit op outside low range");
	a_sp_read: assert property (
		reg_rd && reg_addr == OFS_SP_LOW |=> reg_rdata == $past(stack_ptr[7:0]))
		else $error("stack pointer read");
	c_call: cover property (take && instr.op == OP_CALL);
	c_io_write: cover property (result.io_wr);
	c_branch: cover property (take && instr.op == OP_BRANCH_SAME_HIGHER);
endmodule

bind cab_core cab_core_properties u_cab_core_properties (.core_clk, .srst, .clk_en, .issue,
	.instr, .z_ptr, .stack_pc, .reg_addr, .reg_rd, .reg_rdata, .result, .result_valid, .busy,
	.pc, .status, .stack_ptr);

// ===== bench/testbench.sv
// Purpose: self-checking bench for the execution core
// Assumes: 50 MHz clock, reset held five cycles
// Notes: z feeds the pointer, stack and I/O read inputs alike
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cab_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic issue = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	cab_instr_type instr = '0;
	cab_instr_type i = '0;
	logic [15:0] z_ptr = 16'h0;
	logic [15:0] stack_pc = 16'h0;
	logic [7:0] io_rdata = 8'h0;
	logic [5:0] reg_addr = 6'h0;
	logic [7:0] reg_wdata = 8'h0;
	logic [7:0] reg_rdata, status;
	cab_result_type result;
	logic result_valid, busy;
	logic [15:0] pc, stack_ptr, rp, rl, iw;
	logic [15:0] p = 16'h0;
	logic [15:0] z = 16'h0;
	int failures = 0;
	int compares = 0;
	cab_op_type lo[5] = '{OP_AND, OP_OR, OP_EOR, OP_CBR, OP_TST};
	logic [7:0] lr[5] = '{8'h30, 8'hfc, 8'hcc, 8'hc0, 8'hf0};
	cab_op_type mo[6] = '{OP_MUL, OP_MULS, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_PRODUCT, OP_FMULS, OP_FMULSU};
	logic [16:0] mr[6] = '{17'h04000, 17'h04000, 17'h1c000, 17'h08000, 17'h08000, 17'h18000};
	assign rp = {result.res_hi, result.res_lo};
	assign rl = {8'h0, result.res_lo};
	assign iw = {7'h0, result.io_wr, result.io_wdata};
	always #10 core_clk = ~core_clk;
	cab_core u_cab_core (.core_clk, .srst, .clk_en, .issue, .instr, .z_ptr, .stack_pc, .io_rdata,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .result, .result_valid, .busy, .pc,
		.status, .stack_ptr);
	// ==========
	// Tasks
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk) begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
		end
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge core_clk) begin
			reg_addr <= a;
			reg_rd <= 1'b1;
		end
		@(posedge core_clk) reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h0, e}, {8'h0, reg_rdata});
	endtask
	// Issue one op, count cycles to completion, check pc and flags
	task automatic ex(input cab_op_type o, input logic [7:0] d, input logic [7:0] s, input int n,
		input logic [7:0] es, input logic [15:0] dp);
		int c;
		i.op = o;
		i.dst = d;
		i.src = s;
		@(posedge core_clk) begin
			instr <= i;
			issue <= 1'b1;
			z_ptr <= z;
			stack_pc <= z;
			io_rdata <= z[7:0];
		end
		@(posedge core_clk) issue <= 1'b0;
		c = 0;
		do begin
			@(posedge core_clk);
			#1 c++;
		end while (result_valid !== 1'b1 && c < 9);
		chk("cycles", 16'(n), 16'(c));
		chk("pc", p + dp, pc);
		chk("status", {8'h0, es}, {8'h0, status});
		p = p + dp;
		$display("test %s done", o.name());
	endtask
	// ==========
	// Watchdog
	initial begin
		#100us;
		failures++;
		test_done();
	end
	// ==========
	// Sequence
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		rd(OFS_STATUS, 8'h00);
		rd(OFS_SP_HIGH, 8'h00);
		wr(OFS_SP_HIGH, 8'h12);
		wr(OFS_SP_LOW, 8'h34);
		rd(OFS_SP_LOW, 8'h34);
		chk("stack_ptr", 16'h1234, stack_ptr);
		@(posedge core_clk) clk_en <= 1'b0;
		wr(OFS_SP_LOW, 8'h56);
		#1 chk("frozen_sp", 16'h1234, stack_ptr);
		@(posedge core_clk) clk_en <= 1'b1;
		wr(6'h20, 8'hff);
		rd(6'h20, 8'h00);
		$display("test registers done");
		wr(OFS_STATUS, 8'h01);
		ex(OP_ADC, 8'h0f, 8'h01, 1, 8'h20, 16'h1);
		chk("res", 16'h0011, rl);
		wr(OFS_STATUS, 8'h03);
		ex(OP_SBC, 8'h10, 8'h0f, 1, 8'h22, 16'h1);
		chk("res", 16'h0000, rl);
		ex(OP_MINUS_CONSTANT, 8'h00, 8'h01, 1, 8'h25, 16'h1);
		chk("res", 16'h00ff, rl);
		ex(OP_CPI, 8'h50, 8'h50, 1, 8'h02, 16'h1);
		chk("wr_lo", 16'h0, {15'h0, result.wr_lo});
		wr(OFS_STATUS, 8'h00);
		i.dst_hi = 8'h7f;
		ex(OP_WORD_PLUS_IMMEDIATE, 8'hff, 8'h01, 2, 8'h0c, 16'h1);
		chk("word", 16'h8000, rp);
		i.dst_hi = 8'h00;
		ex(OP_WORD_MINUS_IMMEDIATE, 8'h00, 8'h01, 2, 8'h15, 16'h1);
		chk("word", 16'hffff, rp);
		rd(OFS_STATUS, 8'h15);
		foreach (lo[k]) begin
			wr(OFS_STATUS, 8'h3b);
			ex(lo[k], 8'hf0, 8'h3c, 1, (k == 0) ? 8'h31 : 8'h35, 16'h1);
			chk("res", {8'h0, lr[k]}, rl);
		end
		wr(OFS_STATUS, 8'h3c);
		foreach (mo[k]) begin
			ex(mo[k], 8'h80, 8'h80, 2, {7'h1e, mr[k][16]}, 16'h1);
			chk("product", mr[k][15:0], rp);
		end
		wr(OFS_STATUS, 8'h40);
		i.target = 16'h0010;
		ex(OP_RELATIVE_SUBROUTINE_JUMP, 8'h00, 8'h00, 3, 8'h40, 16'h0011);
		i.target = 16'h0200;
		p = 16'h0200;
		ex(OP_CALL, 8'h00, 8'h00, 4, 8'h40, 16'h0);
		z = 16'h1234;
		p = z;
		ex(OP_POINTER_JUMP, 8'h00, 8'h00, 2, 8'h40, 16'h0);
		z = 16'h0abc;
		p = z;
		ex(OP_POINTER_SUBROUTINE_JUMP, 8'h00, 8'h00, 3, 8'h40, 16'h0);
		z = 16'h0300;
		p = z;
		ex(OP_INTERRUPT_RETURN, 8'h00, 8'h00, 4, 8'hc0, 16'h0);
		i.target = 16'hfffe;
		i.bsel = 3'h6;
		i.pol = 1'b1;
		ex(OP_BRFLAG, 8'h00, 8'h00, 2, 8'hc0, 16'hffff);
		i.pol = 1'b0;
		ex(OP_BRFLAG, 8'h00, 8'h00, 1, 8'hc0, 16'h1);
		ex(OP_BRANCH_SAME_HIGHER, 8'h00, 8'h00, 2, 8'hc0, 16'hffff);
		wr(OFS_STATUS, 8'h01);
		ex(OP_BRANCH_SAME_HIGHER, 8'h00, 8'h00, 1, 8'h01, 16'h1);
		i.next_two_word = 1'b1;
		ex(OP_COMPARE_SKIP_EQUAL, 8'h55, 8'h55, 3, 8'h01, 16'h3);
		i.next_two_word = 1'b0;
		ex(OP_COMPARE_SKIP_EQUAL, 8'h55, 8'h55, 2, 8'h01, 16'h2);
		ex(OP_COMPARE_SKIP_EQUAL, 8'h55, 8'h54, 1, 8'h01, 16'h1);
		i.bsel = 3'h3;
		ex(OP_SKRB, 8'h08, 8'h08, 1, 8'h01, 16'h1);
		i.pol = 1'b1;
		ex(OP_SKRB, 8'h08, 8'h08, 2, 8'h01, 16'h2);
		z = 16'h0;
		i.bsel = 3'h7;
		i.pol = 1'b0;
		i.next_two_word = 1'b1;
		ex(OP_SKIO, 8'h00, 8'h00, 3, 8'h01, 16'h3);
		z = 16'h0081;
		i.bsel = 3'h1;
		i.io_addr = 6'h05;
		ex(OP_IOSET, 8'h00, 8'h00, 1, 8'h01, 16'h1);
		chk("io", 16'h0183, iw);
		z = 16'h00ff;
		i.bsel = 3'h0;
		i.io_addr = 6'h1f;
		ex(OP_IOCLR, 8'h00, 8'h00, 1, 8'h01, 16'h1);
		chk("io", 16'h01fe, iw);
		i.io_addr = 6'h20;
		ex(OP_IOSET, 8'h00, 8'h00, 1, 8'h01, 16'h1);
		chk("io_wr", 16'h0, {15'h0, iw[8]});
		test_done();
	end
endmodule
